// [logic/ecpl_pkg.sv]
// Package: constants and carrier types for the ECP parallel port link
package ecpl_pkg;
	localparam logic [2:0] MODE_STD = 3'h0;
	localparam logic [2:0] MODE_BIDIR = 3'h1;
	localparam logic [2:0] MODE_FIFO = 3'h2;
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam int QUEUE_DEPTH = 16;
	localparam int QUEUE_WIDTH = 9;
	localparam int CMD_BIT = 8;
	localparam logic [4:0] LEVEL_RESET = 5'h08;
	localparam logic [4:0] DEPTH_COUNT = 5'h10;

	typedef struct packed {
		logic is_cmd;
		logic [7:0] byte_val;
	} ecpl_word_t;

	typedef struct packed {
		logic busy;
		logic n_ack;
		logic n_ack_reverse;
		logic n_fault;
		logic select;
	} ecpl_pins_in_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_STROBE = 5'b00100,
		ST_WAIT_FREE = 5'b01000,
		ST_REV_ACK = 5'b10000
	} ecpl_state_t;
endpackage

// [logic/ecpl_queue.sv]
// Shared byte queue with valid/ready on both sides
`timescale 1ns/100ps
module ecpl_queue
	import ecpl_pkg::*;
#(
	parameter int WIDTH = QUEUE_WIDTH,
	parameter int DEPTH = QUEUE_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// [logic/ecpl_port.sv]
// ECP parallel port link: host queue ports, peripheral handshake engine
// Functional notes
// RL1 - nStrobe latches forward byte, interlocked with Busy
// RL2 - PD lines carry address, data or counts
// RL3 - Peripheral asserts nAck for reverse data
// RL4 - Peripheral drops Busy when ready for more
// RL5 - PeriphAck low marks reverse command, top zero
// RL6 - HostAck high data, low command byte
// RL7 - nAckReverse low acknowledges reverse request
// RL8 - Drive PD only when bus released to host
// RL9 - nFault raises error, forward direction only
// RL10 - Peripheral may pull nFault for reverse
// RL11 - nReverseRequest low selects reverse direction
// RL12 - nAutoFd asserted requests reverse byte
// RL13 - nSelectIn held deasserted in ECP mode
// RL14 - Driver clears bits then sets mode 011
// RL15 - Address queue bytes sent as commands
// RL16 - Automatic handshake only in modes 011, 010
// RL17 - Leave non-base modes only to 000/001
// RL18 - Direction changes only in mode 001
// RL19 - Software drains queue before mode return
// RL20 - RLE count to address port, byte data
// RL21 - Service threshold from configuration register 5
// RL22 - Queue only in FIFO/ECP modes, off reset
// RL23 - All queue ports share sixteen bytes
// RL24 - Mode 000 flushes the queue
// RL25 - Service flag set at threshold without DMA
// RL26 - No new strobe before Busy handshake completes
// RL27 - Empty forward queue idles with strobe off
`timescale 1ns/100ps
module ecpl_port
	import ecpl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [2:0] mode_req,
	input wire logic mode_write,
	input wire logic dir_req,
	input wire logic dir_write,
	input wire logic dma_allow_bit,
	input wire logic service_clear,
	input wire logic [4:0] free_space_trigger_level,
	input wire logic level_write,
	input wire logic [7:0] address_rle_queue_port,
	input wire logic address_rle_write,
	input wire logic [7:0] data_queue_port,
	input wire logic data_write,
	input wire logic data_read,
	input wire logic fault_clear,
	input wire logic pin_busy,
	input wire logic pin_n_ack,
	input wire logic pin_n_ack_reverse,
	input wire logic pin_n_fault,
	input wire logic pin_select,
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic pd_oe,
	output logic n_strobe,
	output logic n_auto_fd,
	output logic n_reverse_request,
	output logic n_select_in,
	output logic [2:0] mode,
	output logic direction,
	output logic service_request_flag,
	output logic fault_flag,
	output logic queue_full,
	output logic queue_empty,
	output logic write_ready,
	output logic [7:0] read_data,
	output logic read_is_cmd,
	output logic read_valid,
	output logic online
);
	ecpl_pins_in_t pins_meta;
	ecpl_pins_in_t pins;
	logic [7:0] pd_meta;
	logic [7:0] pd_sync;
	logic fault_prev;
	logic [4:0] level;
	ecpl_state_t state;
	logic auto_hs;
	logic q_in_valid;
	logic q_in_ready;
	ecpl_word_t q_in;
	logic q_out_valid;
	logic q_out_ready;
	ecpl_word_t q_out;
	logic [4:0] q_count;
	logic rev_take;
	logic flush;

	// Two-stage sync of all peripheral pins
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pins_meta <= '1;
			pins <= '1;
			pd_meta <= '0;
			pd_sync <= '0;
		end
		else
		begin
			pins_meta <= '{pin_busy, pin_n_ack, pin_n_ack_reverse,
				pin_n_fault, pin_select};
			pins <= pins_meta;
			pd_meta <= pd_in;
			pd_sync <= pd_meta;
		end
	end

	assign auto_hs = (mode == MODE_ECP) || (mode == MODE_FIFO); // RL16
	assign flush = (mode == MODE_STD); // RL24

	// Mode and direction registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode <= MODE_RESET; // RL22
			direction <= 1'b0;
		end
		else
		begin
			if (mode_write && (mode == MODE_STD || mode == MODE_BIDIR
				|| mode_req == MODE_STD || mode_req == MODE_BIDIR))
				mode <= mode_req; // RL17
			if (dir_write && mode == MODE_BIDIR)
				direction <= dir_req; // RL18
		end
	end

	// Threshold register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			level <= LEVEL_RESET;
		else if (level_write)
			level <= free_space_trigger_level; // RL21
	end

	// Host writes: address port becomes command bytes
	always_comb
	begin
		q_in.is_cmd = address_rle_write; // RL15 RL20
		q_in.byte_val = address_rle_write ? address_rle_queue_port
			: data_queue_port;
		q_in_valid = 1'b0;
		if (auto_hs && !direction)
			q_in_valid = address_rle_write || data_write; // RL22
		else if (auto_hs && direction)
			q_in_valid = rev_take;
	end

	assign rev_take = (state == ST_REV_ACK) && !pins.n_ack
		&& q_in_ready; // RL3
	assign q_out_ready = direction ? (data_read && auto_hs)
		: (state == ST_SETUP);

	ecpl_queue #(.WIDTH(QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH)) u_queue // RL23
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.flush(flush),
		.in_valid(q_in_valid),
		.in_ready(q_in_ready),
		.in_data(direction ? {!pins.busy, pd_sync} : q_in), // RL5
		.out_valid(q_out_valid),
		.out_ready(q_out_ready),
		.out_data(q_out),
		.count(q_count)
	);

	// Handshake engine
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			n_strobe <= 1'b1;
			n_auto_fd <= 1'b1;
			pd_out <= '0;
		end
		else
		begin
			case (state)
			ST_IDLE:
			begin
				n_strobe <= 1'b1; // RL27
				n_auto_fd <= 1'b1;
				if (auto_hs && !direction && q_out_valid && !pins.busy)
					state <= ST_SETUP; // RL26
				else if (auto_hs && direction && !pins.n_ack_reverse
					&& pins.n_ack) // RL3
				begin
					n_auto_fd <= 1'b0; // RL12
					state <= ST_REV_ACK;
				end
			end
			ST_SETUP:
			begin
				pd_out <= q_out.byte_val; // RL2
				n_auto_fd <= !q_out.is_cmd; // RL6
				state <= ST_STROBE;
			end
			ST_STROBE:
			begin
				n_strobe <= 1'b0; // RL1
				if (pins.busy)
					state <= ST_WAIT_FREE;
			end
			ST_WAIT_FREE:
			begin
				n_strobe <= 1'b1;
				if (!pins.busy) // RL4 RL26
					state <= ST_IDLE;
			end
			ST_REV_ACK:
			begin
				if (rev_take || !auto_hs)
				begin
					n_auto_fd <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers; bus only when peripheral has released it
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pd_oe <= 1'b0;
			n_reverse_request <= 1'b1;
			n_select_in <= 1'b1;
		end
		else
		begin
			pd_oe <= !direction && pins.n_ack_reverse; // RL8 RL7
			n_reverse_request <= !direction; // RL11
			n_select_in <= 1'b1; // RL13
		end
	end

	// Error flag: set wins over clear
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_prev <= 1'b1;
			fault_flag <= 1'b0;
		end
		else
		begin
			fault_prev <= pins.n_fault;
			if (fault_prev && !pins.n_fault && !direction) // RL9
				fault_flag <= 1'b1;
			else if (fault_clear)
				fault_flag <= 1'b0;
		end
	end

	// Service flag; only armed when already clear and DMA off
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			service_request_flag <= 1'b0;
		else if (!service_request_flag && !dma_allow_bit && auto_hs
			&& (direction ? (q_count >= level)
			: ((DEPTH_COUNT - q_count) >= level)))
			service_request_flag <= 1'b1; // RL25
		else if (service_clear)
			service_request_flag <= 1'b0;
	end

	// Status outputs registered
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			queue_full <= 1'b0;
			queue_empty <= 1'b1;
			write_ready <= 1'b0;
			read_data <= '0;
			read_is_cmd <= 1'b0;
			read_valid <= 1'b0;
			online <= 1'b0;
		end
		else
		begin
			queue_full <= !q_in_ready;
			queue_empty <= !q_out_valid;
			write_ready <= q_in_ready && auto_hs && !direction;
			read_data <= q_out.byte_val;
			read_is_cmd <= q_out.is_cmd;
			read_valid <= q_out_valid && direction;
			online <= pins.select;
		end
	end
endmodule

// [sim/ecpl_port_chk.sv]
// Checker: pin, mode and queue assertions
`timescale 1ns/100ps
module ecpl_chk
	import ecpl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pin_busy,
	input wire logic pin_n_ack_reverse,
	input wire logic n_strobe,
	input wire logic n_select_in,
	input wire logic pd_oe,
	input wire logic [2:0] mode,
	input wire logic direction,
	input wire logic write_ready,
	input wire logic queue_empty
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	function automatic logic base(logic [2:0] m);
		return m == MODE_STD || m == MODE_BIDIR;
	endfunction
	// Aborts on a mode change are not handshakes
	sequence s_end;
		$rose(n_strobe) && !base(mode) && !base($past(mode));
	endsequence
	sequence s_start;
		$fell(n_strobe);
	endsequence
	a_sel_off: assert property (mode == MODE_ECP |-> n_select_in)
		else $error("select-in low");
	a_bus_rel: assert property (!pin_n_ack_reverse [*4] |-> !pd_oe)
		else $error("bus driven");
	a_dir_lock: assert property ($changed(direction) |->
		$past(mode) == MODE_BIDIR) else $error("direction moved");
	a_mode_path: assert property ($changed(mode) |->
		base(mode) || base($past(mode))) else $error("bad mode");
	a_std_flush: assert property
		(mode == MODE_STD [*3] |-> queue_empty) else $error("no flush");
	a_hold_busy: assert property (s_end |-> $past(pin_busy, 3))
		else $error("strobe early");
	a_next_byte: assert property (s_start |-> !$past(pin_busy, 3))
		else $error("strobe overlap");
	a_q_modes: assert property (write_ready |-> !base(mode)
		|| !base($past(mode))) else $error("queue open");
endmodule
bind ecpl_port ecpl_chk u_chk (.sys_clk, .rst_n, .pin_busy,
	.pin_n_ack_reverse, .n_strobe, .n_select_in, .pd_oe, .mode,
	.direction, .write_ready, .queue_empty);

// [sim/ecpl_peer.sv]
// Peripheral model: forward sink, reverse source
`timescale 1ns/100ps
module ecpl_peer
(
	input wire logic clk,
	input wire logic n_strobe,
	input wire logic n_auto_fd,
	input wire logic n_reverse_request,
	input wire logic [7:0] pd_out,
	input wire logic pd_oe,
	output logic busy,
	output logic n_ack,
	output logic n_ack_reverse,
	output logic [7:0] pd
);
	logic [8:0] rx[$];
	logic [8:0] tx[$];
	int lag = 0;
	initial
	begin
		busy = 0;
		n_ack = 1;
		n_ack_reverse = 1;
		pd = 8'h00;
	end
	always @(negedge n_strobe)
	begin
		rx.push_back({~n_auto_fd, pd_oe ? pd_out : ~pd_out});
		repeat (lag) @(negedge clk);
		busy <= 1;
		@(posedge n_strobe);
		repeat (lag) @(negedge clk);
		busy <= 0;
	end
	always @(n_reverse_request)
	begin
		repeat (lag + 2) @(negedge clk);
		n_ack_reverse <= n_reverse_request;
	end
	always @(negedge clk)
		if (!n_auto_fd && !n_ack_reverse && n_ack && tx.size() > 0)
		begin
			{busy, pd} <= tx.pop_front();
			repeat (lag + 1) @(negedge clk);
			n_ack <= 0;
			@(posedge n_auto_fd);
			@(negedge clk);
			n_ack <= 1;
			pd <= ~pd;
		end
endmodule

// [sim/tb.sv]
// Testbench: host sequences against the peripheral model
`timescale 1ns/100ps
module tb;
	import ecpl_pkg::*;
	logic sys_clk = 0, rst_n = 0, mode_write = 0, dir_req = 0;
	logic dir_write = 0, dma_allow_bit = 0, service_clear = 0;
	logic level_write = 0, address_rle_write = 0, data_write = 0;
	logic data_read = 0, fault_clear = 0, pin_n_fault = 1, pin_select = 1;
	logic [2:0] mode_req = 3'h0;
	logic [4:0] free_space_trigger_level = 5'h11;
	logic [7:0] address_rle_queue_port = 8'h00, data_queue_port = 8'h00;
	logic pin_busy, pin_n_ack, pin_n_ack_reverse, pd_oe, n_strobe;
	logic n_auto_fd, n_reverse_request, n_select_in, direction, online;
	logic service_request_flag, fault_flag, queue_full, queue_empty;
	logic write_ready, read_is_cmd, read_valid;
	logic [7:0] pd_in, pd_out, read_data;
	logic [2:0] mode;
	int err_total = 0, checks = 0, i;
	ecpl_port u_dut (.sys_clk, .rst_n, .mode_req, .mode_write, .dir_req,
		.dir_write, .dma_allow_bit, .service_clear, .free_space_trigger_level,
		.level_write, .address_rle_queue_port, .address_rle_write,
		.data_queue_port, .data_write, .data_read, .fault_clear, .pin_busy,
		.pin_n_ack, .pin_n_ack_reverse, .pin_n_fault, .pin_select, .pd_in,
		.pd_out, .pd_oe, .n_strobe, .n_auto_fd, .n_reverse_request,
		.n_select_in, .mode, .direction, .service_request_flag, .fault_flag,
		.queue_full, .queue_empty, .write_ready, .read_data, .read_is_cmd,
		.read_valid, .online);
	ecpl_peer u_peer (.clk(sys_clk), .n_strobe, .n_auto_fd,
		.n_reverse_request, .pd_out, .pd_oe, .busy(pin_busy),
		.n_ack(pin_n_ack), .n_ack_reverse(pin_n_ack_reverse), .pd(pd_in));
	initial
		forever #50 sys_clk = ~sys_clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
		cyc(1);
	endtask
	task automatic set_mode(input logic [2:0] m);
		mode_req = m;
		pulse(mode_write);
		cyc(1);
	endtask
	// Strobes held between back-to-back writes
	task automatic put(input logic cmd, input logic [7:0] b);
		address_rle_queue_port = b;
		data_queue_port = b;
		address_rle_write = cmd;
		data_write = !cmd;
		cyc(1);
	endtask
	task automatic stop_wr;
		address_rle_write = 0;
		data_write = 0;
		cyc(2);
	endtask
	task automatic wait_rx(input int n);
		for (int k = 0; k < 4000 && u_peer.rx.size() < n; k++) cyc(1);
	endtask
	task automatic chk(input string what, input logic [8:0] got,
		input logic [8:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [8:0] exp);
		for (int k = 0; k < 500 && read_valid !== 1'b1; k++) cyc(1);
		chk("rev", {read_is_cmd, read_data}, exp);
		pulse(data_read);
		cyc(1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		err_total++;
		tally_and_finish;
	end
	initial
	begin
		cyc(2);
		rst_n = 1;
		chk("mode", 9'(mode), 9'h000);
		chk("empty", 9'(queue_empty), 9'h001);
		chk("slin", 9'(n_select_in), 9'h001);
		chk("wrdy", 9'(write_ready), 9'h000);
		set_mode(MODE_FIFO);
		set_mode(MODE_ECP);
		chk("mode", 9'(mode), 9'(MODE_FIFO));
		set_mode(MODE_STD);
		set_mode(MODE_BIDIR);
		dir_req = 1;
		pulse(dir_write);
		chk("dir", 9'(direction), 9'h001);
		dir_req = 0;
		pulse(dir_write);
		set_mode(MODE_ECP);
		dir_req = 1;
		pulse(dir_write);
		chk("dir", 9'(direction), 9'h000);
		chk("wrdy", 9'(write_ready), 9'h001);
		u_peer.lag = 3;
		put(1, 8'h05);
		put(0, 8'hA5);
		put(0, 8'h3C);
		stop_wr;
		wait_rx(3);
		chk("fwd0", u_peer.rx[0], 9'h105);
		chk("fwd1", u_peer.rx[1], 9'h0A5);
		chk("fwd2", u_peer.rx[2], 9'h03C);
		cyc(20);
		chk("stb", 9'(n_strobe), 9'h001);
		chk("svc", 9'(service_request_flag), 9'h001);
		pulse(level_write);
		pulse(service_clear);
		cyc(3);
		chk("svc", 9'(service_request_flag), 9'h000);
		pin_n_fault = 0;
		pin_select = 0;
		cyc(6);
		chk("flt", 9'(fault_flag), 9'h001);
		chk("online", 9'(online), 9'h000);
		pin_n_fault = 1;
		pin_select = 1;
		pulse(fault_clear);
		u_peer.lag = 40;
		for (i = 0; i < 17; i++) put(0, 8'(i));
		stop_wr;
		chk("full", 9'(queue_full), 9'h001);
		put(0, 8'hEE);
		stop_wr;
		wait_rx(20);
		cyc(200);
		chk("cnt", 9'(u_peer.rx.size()), 9'h014);
		chk("last", u_peer.rx[19], 9'h010);
		for (i = 0; i < 4; i++) put(0, 8'(i));
		stop_wr;
		set_mode(MODE_STD);
		chk("flush", 9'(queue_empty), 9'h001);
		u_peer.lag = 2;
		u_peer.tx.push_back(9'h15A);
		u_peer.tx.push_back(9'h021);
		set_mode(MODE_BIDIR);
		pulse(dir_write);
		set_mode(MODE_ECP);
		rd(9'h05A);
		rd(9'h121);
		chk("nrev", 9'(n_reverse_request), 9'h000);
		chk("oe", 9'(pd_oe), 9'h000);
		pin_n_fault = 0;
		cyc(6);
		chk("flt", 9'(fault_flag), 9'h000);
		chk("drain", 9'(queue_empty), 9'h001);
		set_mode(MODE_STD);
		chk("mode", 9'(mode), 9'(MODE_STD));
		chk("online", 9'(online), 9'h001);
		tally_and_finish;
	end
endmodule
